// ===== rtl/tzs_consts.vh
// Constants for the timer with prescaler, postscaler and interrupt.
`ifndef TZS_CONSTS_VH
`define TZS_CONSTS_VH
`define TZS_ADDR_W          4
`define TZS_OFF_CTRL_A      4'h0
`define TZS_OFF_CTRL_B      4'h4
`define TZS_OFF_CNT_LOW     4'h8
`define TZS_OFF_CNT_HIGH    4'hc
`define TZS_OFF_IRQ_STAT    4'h1
`define TZS_OFF_IRQ_MASK    4'h2
`define TZS_CA_ENABLE       7
`define TZS_CA_OUT_STATUS   5
`define TZS_CA_MODE16       4
`define TZS_CA_POST_LSB     0
`define TZS_CB_ASYNC        4
`define TZS_CB_PRE_LSB      0
`define TZS_IRQ_TIMER       0
`define TZS_IRQ_W           1
`define TZS_CTRL_A_RST      8'h00
`define TZS_CTRL_B_RST      8'h00
`define TZS_MASK_RST        1'b0
`endif

// ===== rtl/tzs_prescaler.v
// Power-of-two input prescaler producing one tick per selected number of input edges.
`timescale 1ns/10ps
`default_nettype none
module tzs_prescaler #(
   parameter WIDTH = 15
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Control
   input  wire         clear_i,
   input  wire         edge_i,
   input  wire [3:0]   select_i,
   // Result
   output reg          tick_o
);
   reg [WIDTH-1:0] count_r;
   wire [WIDTH-1:0] limit = (({{(WIDTH-1){1'b0}}, 1'b1} << select_i) - {{(WIDTH-1){1'b0}}, 1'b1});

   always @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_r <= {WIDTH{1'b0}};
         tick_o  <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (edge_i) begin
            if (count_r >= limit) begin
               count_r <= {WIDTH{1'b0}};
               tick_o  <= 1'b1;
            end else begin
               count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/tzs_postscaler.v
// Output postscaler passing one of every N+1 counter events.
`timescale 1ns/10ps
`default_nettype none
module tzs_postscaler (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Control
   input  wire         clear_i,
   input  wire         event_i,
   input  wire [3:0]   select_i,
   // Result
   output reg          pulse_o
);
   reg [3:0] count_r;

   always @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_r <= 4'h0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (event_i) begin
            if (count_r >= select_i) begin
               count_r <= 4'h0;
               pulse_o <= 1'b1;
            end else begin
               count_r <= count_r + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/tzs_timer.v
// Timer top: Wishbone registers, counter, match and rollover, output and interrupt.
// Overview of operation
// - The prescaler divides the counting clock by one of sixteen powers of two from 1 to 32768.
// - The prescale ratio comes from a four-bit field in the second control register.
// - The prescaler count is hidden and clears on a low byte write, any control write and reset.
// - The postscaler divides counter events by one to sixteen, selected by a four-bit field in control register one.
// - The postscaler count is hidden and clears on a low byte write, any control write and reset.
// - During sleep with synchronous clocking the counter stops and holds.
// - During sleep with asynchronous clocking the counter keeps running and an enabled interrupt wakes the device.
// - In 8-bit mode a match occurs when the low byte equals the period byte.
// - In 16-bit mode a rollover occurs when the counter wraps from all ones to zero.
// - The interrupt flag sets once every postscale value plus one events.
// - With the enable bit set, a set flag raises the interrupt and may wake the device.
// - The output pulse lasts one system clock cycle on each postscaled match or rollover.
// - The visible output toggles on each output pulse, giving a square wave readable as a status bit.
`timescale 1ns/10ps
`default_nettype none
`include "tzs_consts.vh"
module tzs_timer #(
   parameter PRE_W = 15
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Wishbone slave
   input  wire         cyc_i,
   input  wire         stb_i,
   input  wire         we_i,
   input  wire [3:0]   adr_i,
   input  wire [7:0]   dat_i,
   output reg  [7:0]   dat_o,
   output reg          ack_o,
   // Timer clock and power state
   input  wire         tmr_clk_pin_i,
   input  wire         sleep_i,
   // Outputs
   output reg          timer_output_pulse_o,
   output reg          timer_output_status_o,
   output reg          irq_o,
   output reg          wake_o
);
   reg  [7:0]   timer_control_a_r;
   reg  [7:0]   timer_control_b_r;
   reg  [7:0]   count_low_byte_r;
   reg  [7:0]   count_high_period_byte_r;
   reg  [7:0]   high_buf_r;
   reg          timer_irq_flag_r;
   reg          timer_irq_enable_r;
   reg          pin_s1_r;
   reg          pin_s2_r;
   reg          pin_s3_r;
   wire         pre_tick;
   wire         post_pulse;

   function is_addr;
      input [3:0] a;
      input [3:0] off;
      begin
         is_addr = (a == off);
      end
   endfunction

   wire req     = cyc_i && stb_i && !ack_o;
   wire wr      = req && we_i;
   wire wr_ca   = wr && is_addr(adr_i, `TZS_OFF_CTRL_A);
   wire wr_cb   = wr && is_addr(adr_i, `TZS_OFF_CTRL_B);
   wire wr_lo   = wr && is_addr(adr_i, `TZS_OFF_CNT_LOW);
   wire wr_hi   = wr && is_addr(adr_i, `TZS_OFF_CNT_HIGH);
   wire wr_st   = wr && is_addr(adr_i, `TZS_OFF_IRQ_STAT);
   wire wr_mk   = wr && is_addr(adr_i, `TZS_OFF_IRQ_MASK);
   wire scaler_clear = wr_lo || wr_ca || wr_cb;
   wire enabled = timer_control_a_r[`TZS_CA_ENABLE];
   wire mode16  = timer_control_a_r[`TZS_CA_MODE16];
   wire async   = timer_control_b_r[`TZS_CB_ASYNC];
   wire run     = enabled && (!sleep_i || async);
   wire pin_rise = pin_s2_r && !pin_s3_r;

   // The pin is synchronised, so counting edges must be under half the system clock rate.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= tmr_clk_pin_i;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   tzs_prescaler #(
      .WIDTH    (PRE_W)
   ) u_pre (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clear_i  (scaler_clear),
      .edge_i   (run && pin_rise),
      .select_i (timer_control_b_r[`TZS_CB_PRE_LSB +: 4]),
      .tick_o   (pre_tick)
   );

   wire [15:0] full_counter = {high_buf_r, count_low_byte_r};
   wire        match8 = !mode16 && (count_low_byte_r == count_high_period_byte_r);
   wire        roll16 = mode16 && (full_counter == 16'hffff);
   wire        cnt_event = pre_tick && (match8 || roll16);

   tzs_postscaler u_post (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clear_i  (scaler_clear),
      .event_i  (cnt_event),
      .select_i (timer_control_a_r[`TZS_CA_POST_LSB +: 4]),
      .pulse_o  (post_pulse)
   );

   // Counter and registers.
   always @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_a_r        <= `TZS_CTRL_A_RST;
         timer_control_b_r        <= `TZS_CTRL_B_RST;
         count_low_byte_r         <= 8'h00;
         count_high_period_byte_r <= 8'h00;
         high_buf_r               <= 8'h00;
         timer_irq_enable_r       <= `TZS_MASK_RST;
      end else begin
         if (wr_ca) begin
            timer_control_a_r <= dat_i;
         end
         if (wr_cb) begin
            timer_control_b_r <= dat_i;
         end
         if (wr_mk) begin
            timer_irq_enable_r <= dat_i[`TZS_IRQ_TIMER];
         end
         // Clearing on the matching tick gives one event per period of the period byte plus one ticks.
         if (wr_lo) begin
            count_low_byte_r <= dat_i;
         end else if (pre_tick) begin
            if (mode16) begin
               {high_buf_r, count_low_byte_r} <= full_counter + 16'h0001;
            end else if (match8) begin
               count_low_byte_r <= 8'h00;
            end else begin
               count_low_byte_r <= count_low_byte_r + 8'h01;
            end
         end
         if (wr_hi) begin
            count_high_period_byte_r <= dat_i;
            high_buf_r               <= dat_i;
         end
      end
   end

   // Output, flag and bus answer.
   always @(posedge clk_i) begin
      if (rst_i) begin
         timer_output_pulse_o  <= 1'b0;
         timer_output_status_o <= 1'b0;
         timer_irq_flag_r      <= 1'b0;
         irq_o                 <= 1'b0;
         wake_o                <= 1'b0;
         ack_o                 <= 1'b0;
         dat_o                 <= 8'h00;
      end else begin
         timer_output_pulse_o <= post_pulse;
         if (post_pulse) begin
            timer_output_status_o <= !timer_output_status_o;
         end
         // A new event wins over a clearing write in the same cycle.
         if (post_pulse) begin
            timer_irq_flag_r <= 1'b1;
         end else if (wr_st && dat_i[`TZS_IRQ_TIMER]) begin
            timer_irq_flag_r <= 1'b0;
         end
         irq_o  <= timer_irq_flag_r && timer_irq_enable_r;
         wake_o <= timer_irq_flag_r && timer_irq_enable_r && sleep_i;
         ack_o  <= req;
         if (req && !we_i) begin
            case (adr_i)
               `TZS_OFF_CTRL_A: dat_o <= {timer_control_a_r[7:6], timer_output_status_o,
                                          timer_control_a_r[4:0]};
               `TZS_OFF_CTRL_B: dat_o <= timer_control_b_r;
               `TZS_OFF_CNT_LOW: dat_o <= count_low_byte_r;
               `TZS_OFF_CNT_HIGH: dat_o <= mode16 ? high_buf_r : count_high_period_byte_r;
               `TZS_OFF_IRQ_STAT: dat_o <= {7'h00, timer_irq_flag_r};
               `TZS_OFF_IRQ_MASK: dat_o <= {7'h00, timer_irq_enable_r};
               default: dat_o <= 8'h00;
            endcase
         end else begin
            dat_o <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/tzs_timer_properties.sv
// Checker for the timer's bus answers, output toggle and interrupt lines.
`timescale 1ns/10ps
`default_nettype none
module tzs_timer_props (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Bus
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       we_i,
   input wire logic [3:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic [7:0] dat_o,
   input wire logic       ack_o,
   // Timer
   input wire logic       sleep_i,
   input wire logic       timer_output_pulse_o,
   input wire logic       timer_output_status_o,
   input wire logic       irq_o,
   input wire logic       wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = cyc_i & stb_i & !ack_o;
   ack_next_a: assert property (req |=> ack_o) else $error("No ack after request.");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("Ack too long.");
   dat_idle_a: assert property (!ack_o |-> dat_o == 8'h00) else $error("Data outside ack.");
   unmapped_zero_a: assert property (req & !we_i & adr_i == 4'h3 |=> dat_o == 8'h00)
      else $error("Unmapped read not zero.");
   out_toggle_a: assert property ((timer_output_status_o != $past(timer_output_status_o)) == timer_output_pulse_o)
      else $error("Status toggle off pulse.");
   status_read_a: assert property (req & !we_i & adr_i == 4'h0 |=> dat_o[5] == $past(timer_output_status_o))
      else $error("Status bit readback wrong.");
   wake_gate_a: assert property (wake_o |-> irq_o && $past(sleep_i)) else $error("Wake without cause.");
   irq_clear_a: assert property (req & we_i & adr_i == 4'h1 & dat_i[0] ##1 !timer_output_pulse_o |=> !irq_o)
      else $error("Irq survives clear.");
   cover property (timer_output_pulse_o);
   cover property (wake_o);
   cover property ($fell(irq_o));
endmodule
bind tzs_timer tzs_timer_props tzs_timer_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
   .dat_o, .ack_o, .sleep_i, .timer_output_pulse_o, .timer_output_status_o, .irq_o, .wake_o);
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the timer through its bus and count pin.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       cyc_i = 1'b0;
   logic       stb_i = 1'b0;
   logic       we_i = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [7:0] dat_i = 8'h00;
   logic       tmr_clk_pin_i = 1'b0;
   logic       sleep_i = 1'b0;
   logic [7:0] dat_o, q;
   logic       ack_o, pulse_o, stat_o, irq_o, wake_o;
   int         fail_count = 0;
   int         compares = 0;
   int         pulses = 0;
   tzs_timer tzs_timer_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .tmr_clk_pin_i,
      .sleep_i, .timer_output_pulse_o(pulse_o), .timer_output_status_o(stat_o), .irq_o, .wake_o);
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) if (pulse_o === 1'b1) pulses <= pulses + 1;
   task automatic end_of_test;
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Two idle cycles after each access let registered status land before checks.
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         fail_count++;
         end_of_test;
      end
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      wb(1'b0, a, 8'h00);
      `CHK(nm, e, q)
   endtask
   // Pin edges are slow against the two-stage synchroniser.
   task automatic pins(input int n);
      repeat (n) begin
         @(posedge clk_i);
         tmr_clk_pin_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         tmr_clk_pin_i <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
   endtask
   task automatic cfg(input logic [7:0] b, h, a);
      wb(1'b1, 4'h4, b);
      wb(1'b1, 4'hc, h);
      wb(1'b1, 4'h0, a);
      wb(1'b1, 4'h8, 8'h00);
      pulses = 0;
   endtask
   initial begin
      #400000;
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 8'h00, "ctrl_a");
      rd(4'h2, 8'h00, "mask");
      wb(1'b1, 4'h3, 8'h5a);
      rd(4'h3, 8'h00, "unmapped");
      for (int s = 0; s < 4; s++) begin
         cfg(s[7:0], 8'hff, 8'h80);
         pins(8);
         rd(4'h8, 8'h08 >> s, "prescale");
      end
      cfg(8'h01, 8'hff, 8'h80);
      pins(1);
      wb(1'b1, 4'h8, 8'h00);
      pins(1);
      rd(4'h8, 8'h00, "pre_clear");
      pins(1);
      rd(4'h8, 8'h01, "pre_run");
      cfg(8'h00, 8'h03, 8'h80);
      wb(1'b1, 4'h2, 8'h01);
      pins(4);
      rd(4'h8, 8'h00, "match_wrap");
      `CHK("pulses", 1, pulses)
      rd(4'h0, 8'ha0, "out_status");
      rd(4'h1, 8'h01, "flag");
      `CHK("irq", 1'b1, irq_o)
      wb(1'b1, 4'h2, 8'h00);
      `CHK("irq_masked", 1'b0, irq_o)
      wb(1'b1, 4'h2, 8'h01);
      wb(1'b1, 4'h1, 8'h01);
      rd(4'h1, 8'h00, "flag_clr");
      `CHK("irq_clr", 1'b0, irq_o)
      cfg(8'h00, 8'h03, 8'h82);
      pins(12);
      `CHK("post_a", 1, pulses)
      pins(8);
      wb(1'b1, 4'h8, 8'h00);
      pins(4);
      `CHK("post_b", 1, pulses)
      pins(8);
      `CHK("post_c", 2, pulses)
      cfg(8'h00, 8'hff, 8'h90);
      wb(1'b1, 4'h8, 8'hfe);
      pins(2);
      rd(4'h8, 8'h00, "roll_low");
      rd(4'hc, 8'h00, "roll_high");
      `CHK("roll_pulse", 1, pulses)
      cfg(8'h00, 8'hff, 8'h80);
      sleep_i <= 1'b1;
      pins(3);
      rd(4'h8, 8'h00, "sync_sleep");
      `CHK("sleep_pulse", 0, pulses)
      cfg(8'h10, 8'h01, 8'h80);
      wb(1'b1, 4'h1, 8'h01);
      `CHK("wake_idle", 1'b0, wake_o)
      pins(3);
      `CHK("wake", 1'b1, wake_o)
      rd(4'h8, 8'h01, "async_run");
      end_of_test;
   end
endmodule
`default_nettype wire
